/* bitmap_pixel_fetch_scroll.sv */
`timescale 1ns/1ns
// Contract
// - Bitmap is 25 rows of 40 cells, each cell 8 by 8 dots.
// - Cell rows lie 320 bytes apart, row index is y divided by eight.
// - Cells in a row lie 8 bytes apart, cell index is x divided by eight.
// - Byte within the cell is the low three bits of y.
// - Hi-res dot at cell offset k comes from byte bit 7 minus k.
// - Dot 0,0 is upper-left; x grows right, y grows down.
// - Multicolor halves horizontal resolution to 160 with four colours per cell.
// - Multicolor bitmap only when bitmap bit 5 and multicolor bit 4 both set.
// - Multicolor uses each adjacent bit pair as one double-width dot.
// - Multicolor colour sources: background zero, upper, lower screen nibble, colour nibble.
// - Bitmap data comes from an 8K region matching the screen one to one.
// - Fine scroll places the image at any of 8 x and 8 y offsets.
// - Optional 38-column and 24-row windows leave a covered edge area.
// - Bitmap mode follows bit 5 of the first control register.
// - Hi-res set dots use upper screen nibble, clear dots the lower one.
module bitmap_pixel_fetch_scroll
  import bitmap_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [bitmap_pkg::REG_W-1:0] i_addr,
  input wire logic [bitmap_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [bitmap_pkg::DATA_W-1:0] o_rdata,
  output logic [bitmap_pkg::MEM_AW-1:0] o_mem_addr,
  output logic o_mem_rd,
  input wire logic [bitmap_pkg::DATA_W-1:0] i_mem_data,
  output logic [bitmap_pkg::SCR_AW-1:0] o_scr_addr,
  input wire logic [bitmap_pkg::DATA_W-1:0] i_scr_data,
  input wire logic [bitmap_pkg::COLOR_W-1:0] i_col_data,
  output logic [bitmap_pkg::COLOR_W-1:0] o_color,
  output logic o_border,
  output logic o_dot_valid
);
  import bitmap_pkg::*;

  typedef struct packed {
    logic [1:0] div;
    logic [8:0] h;
    logic [7:0] v;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [3:0] bg0;
    logic [3:0] border;
    logic [7:0] rdata;
    logic mem_rd;
    logic cap;
    logic [12:0] mem_addr;
    logic [9:0] scr_addr;
    logic [8:0] fx;
    logic [7:0] fy;
    logic show;
    logic src_ok;
    logic bitmap;
    logic mc;
  } top_state_type;

  top_state_type s;
  top_state_type next_s;
  dot_if dif ();

  logic dot_en;
  logic [8:0] dx;
  logic [7:0] dy;
  logic in_x;
  logic in_y;
  logic [2:0] xscroll;
  logic [2:0] yscroll;
  logic [8:0] fx;
  logic [7:0] fy;
  logic win_x;
  logic win_y;

  assign dot_en = (s.div == DOT_DIV_M1);
  // Display coordinates start at zero at the upper-left dot.
  assign dx = s.h - H_START;
  assign dy = s.v - V_START;
  assign in_x = (s.h >= H_START) && (s.h < H_START + DISP_W);
  assign in_y = (s.v >= V_START) && (s.v < V_START + DISP_H);
  assign xscroll = s.ctrl2[2:0];
  assign yscroll = s.ctrl1[2:0];
  // The image moves right and down by the scroll values.
  assign fx = dx - {6'h00, xscroll};
  assign fy = dy - {5'h00, yscroll};
  assign win_x = s.ctrl2[CTRL2_COLS40] || ((dx >= COL38_LO) && (dx < COL38_HI));
  assign win_y = s.ctrl1[CTRL1_ROWS25] || ((dy >= ROW24_LO) && (dy < ROW24_HI));

  always_comb
  begin
    next_s = s;
    next_s.div = dot_en ? 2'h0 : s.div + 2'h1;
    next_s.mem_rd = 1'b0;
    next_s.cap = s.mem_rd;
    next_s.rdata = 8'h00;
    if (i_wr)
    begin
      unique case (i_addr)
        REG_CTRL1: next_s.ctrl1 = i_wdata;
        REG_CTRL2: next_s.ctrl2 = i_wdata;
        REG_BG0: next_s.bg0 = i_wdata[3:0];
        REG_BORDER: next_s.border = i_wdata[3:0];
        default: ;
      endcase
    end
    if (i_rd)
    begin
      unique case (i_addr)
        REG_CTRL1: next_s.rdata = s.ctrl1;
        REG_CTRL2: next_s.rdata = s.ctrl2;
        REG_BG0: next_s.rdata = {4'h0, s.bg0};
        REG_BORDER: next_s.rdata = {4'h0, s.border};
        REG_RASTER: next_s.rdata = s.v;
        default: next_s.rdata = 8'h00;
      endcase
    end
    if (dot_en)
    begin
      next_s.h = (s.h == H_TOTAL - 9'h001) ? 9'h000 : s.h + 9'h001;
      if (s.h == H_TOTAL - 9'h001)
        next_s.v = (s.v == V_TOTAL - 8'h01) ? 8'h00 : s.v + 8'h01;
      next_s.show = in_x && in_y && win_x && win_y;
      next_s.src_ok = (dx >= {6'h00, xscroll}) && (dy >= {5'h00, yscroll});
      next_s.fx = fx;
      next_s.fy = fy;
      // One byte per 8 dots of a cell line, 320 bytes per cell row.
      next_s.mem_addr = bitmap_addr(fx, fy);
      next_s.scr_addr = screen_addr(fx, fy);
      next_s.mem_rd = in_x && in_y;
      next_s.bitmap = s.ctrl1[CTRL1_BITMAP];
      next_s.mc = s.ctrl1[CTRL1_BITMAP] && s.ctrl2[CTRL2_MULTI];
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      s <= '0;
      s.ctrl1 <= CTRL1_RST;
      s.ctrl2 <= CTRL2_RST;
      s.bg0 <= BG0_RST;
      s.border <= BORDER_RST;
    end
    else
      s <= next_s;
  end

  // Fetched bytes arrive the cycle after the read; the selector latches them then.
  assign dif.dot_en = dot_en;
  assign dif.cap = s.cap;
  assign dif.mem_byte = i_mem_data;
  assign dif.scr_byte = i_scr_data;
  assign dif.col_nib = i_col_data;
  assign dif.bit_ix = s.fx[2:0];
  assign dif.show = s.show;
  assign dif.src_ok = s.src_ok;
  assign dif.bitmap = s.bitmap;
  assign dif.mc = s.mc;
  assign dif.bg0 = s.bg0;
  assign dif.border_col = s.border;

  dot_color_select dot_color_select_i (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .dif(dif)
  );

  assign o_rdata = s.rdata;
  assign o_mem_addr = s.mem_addr;
  assign o_mem_rd = s.mem_rd;
  assign o_scr_addr = s.scr_addr;
  assign o_color = dif.color;
  assign o_border = dif.is_border;
  assign o_dot_valid = dif.valid;

  a_fetch_addr: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    s.mem_rd |-> s.mem_addr == 13'(s.fy[7:3]) * 13'h0140 + {1'b0, s.fx[8:3], 3'h0}
    + 13'(s.fy[2:0]))
    else $error("bitmap byte address wrong");
  a_screen_addr: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    s.mem_rd && s.src_ok |-> s.scr_addr < SCREEN_CELLS && s.fx[8:3] < 6'h28 && s.fy[7:3] < 5'h19)
    else $error("cell outside 40 by 25 grid");
  a_addr_range: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    s.mem_rd && s.src_ok |-> s.mem_addr < BITMAP_BYTES)
    else $error("bitmap fetch outside 8K area");
  a_origin_dot: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    dot_en && s.h == H_START && s.v == V_START && yscroll == 3'h0 && xscroll == 3'h0
    |=> s.mem_rd && s.mem_addr == 13'h0000 && s.scr_addr == 10'h000)
    else $error("upper-left dot not at byte zero");
  a_scroll_shift: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    dot_en && in_x && in_y |=> s.fx == $past(dx) - 9'($past(xscroll))
    && s.fy == $past(dy) - 8'($past(yscroll)))
    else $error("fine scroll offset not applied");
  a_mode_enter: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    dot_en |=> s.mc == ($past(s.ctrl1[CTRL1_BITMAP]) && $past(s.ctrl2[CTRL2_MULTI]))
    && s.bitmap == $past(s.ctrl1[CTRL1_BITMAP]))
    else $error("mode bits not followed");
  a_narrow_cols: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    dot_en && in_y && in_x && !s.ctrl2[CTRL2_COLS40] && dx < COL38_LO
    |-> ##4 (o_border && o_dot_valid))
    else $error("38-column edge not covered");
  a_pair_width: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    s.mem_rd && s.mc && s.fx[0] |-> s.mem_addr == $past(s.mem_addr, 3))
    else $error("multicolor dot halves fetched apart");

  c_hires_dot: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    dot_en && s.show && s.bitmap && !s.mc);
  c_scrolled: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    s.mem_rd && xscroll == 3'h7 && yscroll == 3'h7);
  c_narrow: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_dot_valid && o_border && !s.ctrl1[CTRL1_ROWS25]);
endmodule : bitmap_pixel_fetch_scroll

/* bitmap_pkg.sv */
package bitmap_pkg;
  localparam int REG_W = 3;
  localparam int DATA_W = 8;
  localparam int MEM_AW = 13;
  localparam int SCR_AW = 10;
  localparam int COLOR_W = 4;
  localparam logic [2:0] REG_CTRL1 = 3'h0;
  localparam logic [2:0] REG_CTRL2 = 3'h1;
  localparam logic [2:0] REG_BG0 = 3'h2;
  localparam logic [2:0] REG_BORDER = 3'h3;
  localparam logic [2:0] REG_RASTER = 3'h4;
  localparam int CTRL1_BITMAP = 5;
  localparam int CTRL1_ROWS25 = 3;
  localparam int CTRL2_MULTI = 4;
  localparam int CTRL2_COLS40 = 3;
  localparam logic [7:0] CTRL1_RST = 8'h08;
  localparam logic [7:0] CTRL2_RST = 8'h08;
  localparam logic [3:0] BG0_RST = 4'h0;
  localparam logic [3:0] BORDER_RST = 4'h0;
  localparam logic [8:0] H_TOTAL = 9'h190;
  localparam logic [8:0] H_START = 9'h028;
  localparam logic [8:0] DISP_W = 9'h140;
  localparam logic [7:0] V_TOTAL = 8'hf0;
  localparam logic [7:0] V_START = 8'h14;
  localparam logic [7:0] DISP_H = 8'hc8;
  localparam logic [8:0] COL38_LO = 9'h007;
  localparam logic [8:0] COL38_HI = 9'h137;
  localparam logic [7:0] ROW24_LO = 8'h04;
  localparam logic [7:0] ROW24_HI = 8'hc4;
  localparam logic [12:0] ROW_BYTES = 13'h0140;
  localparam logic [12:0] CELL_BYTES = 13'h0008;
  localparam logic [9:0] ROW_CELLS = 10'h028;
  localparam logic [12:0] BITMAP_BYTES = 13'h1f40;
  localparam logic [9:0] SCREEN_CELLS = 10'h3e8;
  localparam logic [1:0] DOT_DIV_M1 = 2'h2;

  function automatic logic [12:0] bitmap_addr(input logic [8:0] x, input logic [7:0] y);
    bitmap_addr = 13'(y[7:3]) * ROW_BYTES + 13'(x[8:3]) * CELL_BYTES + 13'(y[2:0]);
  endfunction : bitmap_addr

  function automatic logic [9:0] screen_addr(input logic [8:0] x, input logic [7:0] y);
    screen_addr = 10'(y[7:3]) * ROW_CELLS + 10'(x[8:3]);
  endfunction : screen_addr
endpackage : bitmap_pkg

/* dot_if.sv */
`timescale 1ns/1ns
interface dot_if;
  logic dot_en;
  logic cap;
  logic [7:0] mem_byte;
  logic [7:0] scr_byte;
  logic [3:0] col_nib;
  logic [2:0] bit_ix;
  logic show;
  logic src_ok;
  logic bitmap;
  logic mc;
  logic [3:0] bg0;
  logic [3:0] border_col;
  logic [3:0] color;
  logic is_border;
  logic valid;
  modport ctl (output dot_en, cap, mem_byte, scr_byte, col_nib, bit_ix, show, src_ok, bitmap,
    mc, bg0, border_col, input color, is_border, valid);
  modport sel (input dot_en, cap, mem_byte, scr_byte, col_nib, bit_ix, show, src_ok, bitmap,
    mc, bg0, border_col, output color, is_border, valid);
endinterface : dot_if

/* dot_color_select.sv */
`timescale 1ns/1ns
module dot_color_select
  import bitmap_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  dot_if.sel dif
);
  typedef struct packed {
    logic [7:0] pix;
    logic [7:0] scr;
    logic [3:0] col;
    logic [3:0] color;
    logic is_border;
    logic valid;
  } sel_state_type;

  sel_state_type s;
  sel_state_type next_s;
  logic [2:0] pair_shift;
  logic [1:0] pair;

  assign pair_shift = {~dif.bit_ix[2:1], 1'b0};
  assign pair = 2'(s.pix >> pair_shift);

  always_comb
  begin
    next_s = s;
    next_s.valid = dif.dot_en;
    if (dif.cap)
    begin
      next_s.pix = dif.mem_byte;
      next_s.scr = dif.scr_byte;
      next_s.col = dif.col_nib;
    end
    if (dif.dot_en)
    begin
      next_s.is_border = ~dif.show;
      if (!dif.show)
        next_s.color = dif.border_col;
      else if (!dif.bitmap || !dif.src_ok)
        next_s.color = dif.bg0;
      else if (dif.mc)
      begin
        // Both hi-res positions of a pair read the same two bits.
        unique case (pair)
          2'b00: next_s.color = dif.bg0;
          2'b01: next_s.color = s.scr[7:4];
          2'b10: next_s.color = s.scr[3:0];
          2'b11: next_s.color = s.col;
        endcase
      end
      else
        next_s.color = s.pix[3'd7 - dif.bit_ix] ? s.scr[7:4] : s.scr[3:0];
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign dif.color = s.color;
  assign dif.is_border = s.is_border;
  assign dif.valid = s.valid;

  a_hires_color: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    dif.dot_en && dif.show && dif.src_ok && dif.bitmap && !dif.mc |=>
    s.color == (((($past(s.pix) >> (3'd7 - $past(dif.bit_ix))) & 8'h01) != 8'h00) ?
    $past(s.scr[7:4]) : $past(s.scr[3:0])))
    else $error("hi-res dot colour wrong");
  a_multi_color: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    dif.dot_en && dif.show && dif.src_ok && dif.mc && pair == 2'b11 |=> s.color == $past(s.col))
    else $error("multicolor pair 11 not from colour memory");
  a_multi_bg: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    dif.dot_en && dif.show && dif.src_ok && dif.mc && pair == 2'b00 |=> s.color == $past(dif.bg0))
    else $error("multicolor pair 00 not background");
  c_multi_dot: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    dif.dot_en && dif.show && dif.mc && pair == 2'b01);
endmodule : dot_color_select

/* mem_model.sv */
`timescale 1ns/1ns
module mem_model
  import bitmap_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_mem_rd,
  input wire logic [bitmap_pkg::MEM_AW-1:0] i_mem_addr,
  input wire logic [bitmap_pkg::SCR_AW-1:0] i_scr_addr,
  output logic [bitmap_pkg::DATA_W-1:0] o_mem_data,
  output logic [bitmap_pkg::DATA_W-1:0] o_scr_data,
  output logic [bitmap_pkg::COLOR_W-1:0] o_col_data
);
  function automatic logic [7:0] bm_byte(input logic [12:0] a);
    bm_byte = a[7:0] ^ {a[12:8], 3'h6};
  endfunction : bm_byte

  function automatic logic [7:0] scr_byte(input logic [9:0] s);
    scr_byte = s[7:0] ^ 8'h5a;
  endfunction : scr_byte

  function automatic logic [3:0] col_nib(input logic [9:0] s);
    col_nib = s[3:0] ^ 4'h3;
  endfunction : col_nib

  initial
  begin
    o_mem_data = 8'h00;
    o_scr_data = 8'h00;
    o_col_data = 4'h0;
  end

  // Data stand only in the cycle after the fetch; otherwise the lines toggle.
  always @(posedge i_ref_clk)
  begin
    if (i_mem_rd)
    begin
      o_mem_data <= bm_byte(i_mem_addr);
      o_scr_data <= scr_byte(i_scr_addr);
      o_col_data <= col_nib(i_scr_addr);
    end
    else
    begin
      o_mem_data <= ~o_mem_data;
      o_scr_data <= ~o_scr_data;
      o_col_data <= ~o_col_data;
    end
  end
endmodule : mem_model

/* bitmap_pixel_fetch_scroll_tb.sv */
`timescale 1ns/1ns
module bitmap_pixel_fetch_scroll_tb;
  import bitmap_pkg::*;
  logic i_ref_clk = 1'h0;
  logic i_rst_n = 1'h0;
  logic [REG_W-1:0] i_addr = 3'h0;
  logic [DATA_W-1:0] i_wdata = 8'h00;
  logic i_wr = 1'h0;
  logic i_rd = 1'h0;
  logic [DATA_W-1:0] o_rdata, i_mem_data, i_scr_data;
  logic [MEM_AW-1:0] o_mem_addr;
  logic [SCR_AW-1:0] o_scr_addr;
  logic [COLOR_W-1:0] i_col_data, o_color;
  logic o_mem_rd, o_border, o_dot_valid;
  int n_errors = 0, n_compared = 0, cyc = 0, t0 = -1;
  logic [7:0] c1 = 8'h08, c2 = 8'h08, bg = 8'h00, bd = 8'h00;
  logic [2:0] pv = 3'h0, pb = 3'h0;
  logic [3:0] pc [3];
  logic [23:0] sched [4] = '{24'h0a2818, 24'h120818, 24'h142a0b, 24'h1c2f1f};

  bitmap_pixel_fetch_scroll bitmap_pixel_fetch_scroll_i (.i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .i_mem_data(i_mem_data),
    .o_scr_addr(o_scr_addr), .i_scr_data(i_scr_data), .i_col_data(i_col_data),
    .o_color(o_color), .o_border(o_border), .o_dot_valid(o_dot_valid));
  mem_model mem_model_i (.i_ref_clk(i_ref_clk), .i_mem_rd(o_mem_rd), .i_mem_addr(o_mem_addr),
    .i_scr_addr(o_scr_addr), .o_mem_data(i_mem_data), .o_scr_data(i_scr_data),
    .o_col_data(i_col_data));

  initial
  begin
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  task automatic close_out();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %0t register read %h expected %h", $time, g, e);
    end
  endtask : chk_reg

  task automatic chk_addr(input logic [22:0] g, input logic [22:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %0t fetch address %h expected %h", $time, g, e);
    end
  endtask : chk_addr

  task automatic chk_dot(input logic [5:0] g, input logic [5:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %0t dot valid/border/colour %h expected %h", $time, g, e);
    end
  endtask : chk_dot

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    if (a == REG_CTRL1) c1 = d;
    if (a == REG_CTRL2) c2 = d;
    if (a == REG_BG0) bg = d;
    if (a == REG_BORDER) bd = d;
    @(posedge i_ref_clk);
    i_wr <= 1'h1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'h0;
  endtask : wr

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    @(posedge i_ref_clk);
    i_rd <= 1'h1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'h0;
    #1 chk_reg(o_rdata, e);
  endtask : rd_chk

  task automatic wait_line(input int l);
    while (cyc < t0 + 1200 * l - 150) @(posedge i_ref_clk);
  endtask : wait_line

  // Works out the expected dot for a fetch at screen position x, y.
  task automatic on_fetch(input int x, input int y);
    int sx, sy, k, a, s;
    logic [7:0] b, sb;
    logic [3:0] col;
    logic brd;
    brd = (!c2[3] && (x < 7 || x > 310)) || (!c1[3] && (y < 4 || y > 195));
    sx = x - int'(c2[2:0]);
    sy = y - int'(c1[2:0]);
    col = bg[3:0];
    if (c1[5] && sx >= 0 && sy >= 0)
    begin
      a = sy / 8 * 320 + sx / 8 * 8 + sy % 8;
      s = sy / 8 * 40 + sx / 8;
      chk_addr({o_mem_addr, o_scr_addr}, {13'(a), 10'(s)});
      b = mem_model_i.bm_byte(13'(a));
      sb = mem_model_i.scr_byte(10'(s));
      k = 6 - 2 * (sx % 8 / 2);
      if (c2[4])
        case ({b[k + 1], b[k]})
          2'h0: col = bg[3:0];
          2'h1: col = sb[7:4];
          2'h2: col = sb[3:0];
          default: col = mem_model_i.col_nib(10'(s));
        endcase
      else
        col = b[7 - sx % 8] ? sb[7:4] : sb[3:0];
    end
    pv[0] = 1'h1;
    pb[0] = brd;
    pc[0] = brd ? bd[3:0] : col;
  endtask : on_fetch

  // A dot shows three cycles after its fetch pulse.
  always @(posedge i_ref_clk)
  begin
    cyc = cyc + 1;
    if (pv[2])
      chk_dot({o_dot_valid, o_border, o_color}, {1'h1, pb[2], pc[2]});
    pv = {pv[1:0], 1'h0};
    pb = {pb[1:0], 1'h0};
    pc[2] = pc[1];
    pc[1] = pc[0];
    if (i_rst_n && o_mem_rd === 1'h1)
    begin
      if (t0 < 0) t0 = cyc;
      on_fetch((cyc - t0) % 1200 / 3, (cyc - t0) / 1200);
    end
  end

  initial
  begin
    #(8 * 90000);
    n_errors++;
    close_out();
  end

  initial
  begin
    repeat (6) @(posedge i_ref_clk);
    i_rst_n <= 1'h1;
    rd_chk(REG_CTRL1, 8'h08);
    rd_chk(REG_CTRL2, 8'h08);
    rd_chk(REG_BG0, 8'h00);
    rd_chk(REG_BORDER, 8'h00);
    wr(REG_CTRL2, 8'h18);
    rd_chk(REG_CTRL2, 8'h18);
    wr(3'h6, 8'hff);
    rd_chk(3'h6, 8'h00);
    rd_chk(3'h5, 8'h00);
    wr(REG_BG0, 8'h05);
    wr(REG_BORDER, 8'h09);
    wr(REG_CTRL1, 8'h20);
    wr(REG_CTRL2, 8'h00);
    rd_chk(REG_BG0, 8'h05);
    while (t0 < 0) @(posedge i_ref_clk);
    // Mode changes land in horizontal blanking so no dot straddles them.
    foreach (sched[i])
    begin
      wait_line(int'(sched[i][23:16]));
      rd_chk(REG_RASTER, V_START + 8'(sched[i][23:16]) - 8'h01);
      wr(REG_CTRL1, sched[i][15:8]);
      wr(REG_CTRL2, sched[i][7:0]);
    end
    wait_line(36);
    close_out();
  end
endmodule : bitmap_pixel_fetch_scroll_tb
